// File: include/dcs_defs.svh
// Constants of the channel count and status block: offsets, fields, codes.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit offset.
//
// What this block does
// - Status byte sits in bits 31-24, byte count in bits 23-0, one word.
// - Count holds bytes left and drops only on a finished write address.
// - Each step subtracts 1, 2, 4 or 16 for byte, word, long, line.
// - Hardware sets status bits; other software status writes do nothing.
// - Start with count not a size multiple sets config error, no transfer.
// - Config error also on misaligned pointers or start with zero count.
// - Config error clears only on reset or a one written to completion.
// - Bit 5 flags a source-side bus error, zero otherwise.
// - Bit 4 flags a destination-side bus error, zero otherwise.
// - Bit 2 shows work remaining while the channel is not selected.
// - Bit 1 sets when a transfer starts, clears after the last one.
// - Bit 0 sets at the end, by count after the final success or by error.
// - A one written to completion clears all status, interrupt, and aborts.
// - Writing zero to completion, or reading it, has no side effect.
// - Control bit 31 gates the interrupt on completion or error.
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

`define DCS_OFF_COUNT_STATUS 8'h00
`define DCS_OFF_CONTROL      8'h04
`define DCS_OFF_EVT_STATUS   8'h08
`define DCS_OFF_EVT_CLEAR    8'h0C
`define DCS_OFF_EVT_ENABLE   8'h10

`define DCS_STATUS_LSB 24
`define DCS_ST_DONE    0
`define DCS_ST_BUSY    1
`define DCS_ST_REQ     2
`define DCS_ST_BED     4
`define DCS_ST_BES     5
`define DCS_ST_CE      6

`define DCS_CTL_INT_EN   31
`define DCS_CTL_START    8
`define DCS_CTL_SIZE_LSB 0

`define DCS_SIZE_BYTE 2'h0
`define DCS_SIZE_WORD 2'h1
`define DCS_SIZE_LONG 2'h2
`define DCS_SIZE_LINE 2'h3

`define DCS_EVT_DONE 0
`define DCS_EVT_CE   1
`define DCS_EVT_BES  2
`define DCS_EVT_BED  3

`define DCS_STEP_BYTE 24'h00_0001
`define DCS_STEP_WORD 24'h00_0002
`define DCS_STEP_LONG 24'h00_0004
`define DCS_STEP_LINE 24'h00_0010

`define DCS_RESET_STATE '0

`endif

// File: include/dcs_pkg.sv
// Types shared by the channel count and status block and its bench.
// Assumes the constants header is compiled alongside.
package dcs_pkg;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_RUN,
        PH_LAST
    } dcs_phase_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } dcs_apb_req_s;

    typedef struct packed {
        logic       write_addr_done;
        logic       write_done;
        logic       read_error;
        logic       write_error;
        logic       selected;
        logic [3:0] source_pointer;
        logic [3:0] dest_pointer;
    } dcs_engine_s;

    typedef struct packed {
        dcs_phase_e  phase;
        logic [23:0] count;
        logic        ce;
        logic        source_bus_error;
        logic        bed;
        logic        req;
        logic        done;
        logic        int_en;
        logic [1:0]  size;
        logic [3:0]  evt_status;
        logic [3:0]  evt_enable;
        logic [31:0] prdata;
        logic        abort;
    } dcs_state_s;

endpackage

// File: core/dcs_channel.sv
// One channel's byte counter, status byte and interrupt, on an APB slave.
// Assumes a transfer engine on the same clock that reports write address
// completion, write completion, bus errors and arbiter selection.
`include "dcs_defs.svh"

module dcs_channel (
    input  wire logic                 clock_in,
    input  wire logic                 reset_in,
    input  wire dcs_pkg::dcs_apb_req_s apb_in,
    output logic                      pready_out,
    output logic                      pslverr_out,
    output logic [31:0]               prdata_out,
    input  wire dcs_pkg::dcs_engine_s engine_in,
    output logic                      channel_active_out,
    output logic                      pending_out,
    output logic [1:0]                size_out,
    output logic                      abort_out,
    output logic                      irq_out
);
    import dcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    dcs_state_s  st_reg;
    dcs_state_s  st_next;
    logic        setup;
    logic        access;
    logic        wr;
    logic        mapped;
    logic        busy;
    logic [23:0] step;
    logic [3:0]  evt_set;
    logic        bad_config;
    logic [1:0]  new_size;
    logic [31:0] rd_word;

    // Returns one when the low address or count bits break the size.
    function automatic logic misaligned(input logic [1:0] size,
                                        input logic [3:0] value);
        logic result;
        result = 1'b0;
        case (size)
            `DCS_SIZE_BYTE: begin
                result = 1'b0;
            end
            `DCS_SIZE_WORD: begin
                result = value[0];
            end
            `DCS_SIZE_LONG: begin
                result = |value[1:0];
            end
            `DCS_SIZE_LINE: begin
                result = |value[3:0];
            end
            default: begin
                result = 1'b0;
            end
        endcase
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.

    assign setup  = apb_in.psel & ~apb_in.penable;
    assign access = apb_in.psel & apb_in.penable;
    assign wr     = access & apb_in.pwrite;
    assign busy   = (st_reg.phase != PH_IDLE);

    always_comb begin
        case (apb_in.paddr)
            `DCS_OFF_COUNT_STATUS: begin
                mapped = 1'b1;
            end
            `DCS_OFF_CONTROL: begin
                mapped = 1'b1;
            end
            `DCS_OFF_EVT_STATUS: begin
                mapped = 1'b1;
            end
            `DCS_OFF_EVT_CLEAR: begin
                mapped = 1'b1;
            end
            `DCS_OFF_EVT_ENABLE: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Read word, captured during the setup cycle.

    always_comb begin
        rd_word = 32'h0000_0000;
        case (apb_in.paddr)
            `DCS_OFF_COUNT_STATUS: begin
                rd_word[23:0] = st_reg.count;
                rd_word[`DCS_STATUS_LSB + `DCS_ST_CE]   = st_reg.ce;
                rd_word[`DCS_STATUS_LSB + `DCS_ST_BES]  = st_reg.source_bus_error;
                rd_word[`DCS_STATUS_LSB + `DCS_ST_BED]  = st_reg.bed;
                rd_word[`DCS_STATUS_LSB + `DCS_ST_REQ]  = st_reg.req;
                rd_word[`DCS_STATUS_LSB + `DCS_ST_BUSY] = busy;
                rd_word[`DCS_STATUS_LSB + `DCS_ST_DONE] = st_reg.done;
            end
            `DCS_OFF_CONTROL: begin
                rd_word[`DCS_CTL_INT_EN] = st_reg.int_en;
                rd_word[`DCS_CTL_SIZE_LSB +: 2] = st_reg.size;
            end
            `DCS_OFF_EVT_STATUS: begin
                rd_word[3:0] = st_reg.evt_status;
            end
            `DCS_OFF_EVT_ENABLE: begin
                rd_word[3:0] = st_reg.evt_enable;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Step size and start check.

    always_comb begin
        case (st_reg.size)
            `DCS_SIZE_BYTE: begin
                step = `DCS_STEP_BYTE;
            end
            `DCS_SIZE_WORD: begin
                step = `DCS_STEP_WORD;
            end
            `DCS_SIZE_LONG: begin
                step = `DCS_STEP_LONG;
            end
            `DCS_SIZE_LINE: begin
                step = `DCS_STEP_LINE;
            end
            default: begin
                step = `DCS_STEP_BYTE;
            end
        endcase
    end

    // The start check must use the size written along with the start bit.
    assign new_size   = apb_in.pwdata[`DCS_CTL_SIZE_LSB +: 2];
    assign bad_config = (st_reg.count == 24'h00_0000)
                      | misaligned(new_size, st_reg.count[3:0])
                      | misaligned(new_size,
                                   engine_in.source_pointer)
                      | misaligned(new_size,
                                   engine_in.dest_pointer);

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        st_next       = st_reg;
        st_next.abort = 1'b0;
        evt_set       = 4'h0;

        if (setup) begin
            st_next.prdata = rd_word;
        end

        // Transfer engine events.
        case (st_reg.phase)
            PH_IDLE: begin
                st_next.phase = PH_IDLE;
            end
            PH_RUN: begin
                if (engine_in.read_error) begin
                    evt_set[`DCS_EVT_BES]  = 1'b1;
                    evt_set[`DCS_EVT_DONE] = 1'b1;
                    st_next.phase = PH_IDLE;
                end else if (engine_in.write_error) begin
                    evt_set[`DCS_EVT_BED]  = 1'b1;
                    evt_set[`DCS_EVT_DONE] = 1'b1;
                    st_next.phase = PH_IDLE;
                end else if (engine_in.write_addr_done) begin
                    st_next.count = st_reg.count - step;
                    if (st_reg.count == step) begin
                        st_next.phase = PH_LAST;
                    end
                end
            end
            PH_LAST: begin
                if (engine_in.read_error) begin
                    evt_set[`DCS_EVT_BES]  = 1'b1;
                    evt_set[`DCS_EVT_DONE] = 1'b1;
                    st_next.phase = PH_IDLE;
                end else if (engine_in.write_error) begin
                    evt_set[`DCS_EVT_BED]  = 1'b1;
                    evt_set[`DCS_EVT_DONE] = 1'b1;
                    st_next.phase = PH_IDLE;
                end else if (engine_in.write_done) begin
                    evt_set[`DCS_EVT_DONE] = 1'b1;
                    st_next.phase = PH_IDLE;
                end
            end
            default: begin
                st_next.phase = PH_IDLE;
            end
        endcase

        // Software writes.
        if (wr) begin
            case (apb_in.paddr)
                `DCS_OFF_COUNT_STATUS: begin
                    st_next.count = apb_in.pwdata[23:0];
                    // Only the completion bit acts; the others are dropped.
                    if (apb_in.pwdata[`DCS_STATUS_LSB + `DCS_ST_DONE]) begin
                        st_next.ce         = 1'b0;
                        st_next.source_bus_error        = 1'b0;
                        st_next.bed        = 1'b0;
                        st_next.done       = 1'b0;
                        st_next.evt_status = 4'h0;
                        st_next.phase      = PH_IDLE;
                        st_next.abort      = busy;
                    end
                end
                `DCS_OFF_CONTROL: begin
                    st_next.int_en = apb_in.pwdata[`DCS_CTL_INT_EN];
                    st_next.size   = apb_in.pwdata[`DCS_CTL_SIZE_LSB +: 2];
                    if (apb_in.pwdata[`DCS_CTL_START] && !busy) begin
                        if (bad_config) begin
                            evt_set[`DCS_EVT_CE]   = 1'b1;
                            evt_set[`DCS_EVT_DONE] = 1'b1;
                        end else begin
                            st_next.phase = PH_RUN;
                        end
                    end
                end
                `DCS_OFF_EVT_CLEAR: begin
                    st_next.evt_status = st_reg.evt_status
                                       & ~apb_in.pwdata[3:0];
                end
                `DCS_OFF_EVT_ENABLE: begin
                    st_next.evt_enable = apb_in.pwdata[3:0];
                end
                default: begin
                    st_next.evt_enable = st_next.evt_enable;
                end
            endcase
        end

        // Events of this cycle win over any clear of the same cycle.
        st_next.evt_status = st_next.evt_status | evt_set;
        st_next.ce   = st_next.ce   | evt_set[`DCS_EVT_CE];
        st_next.source_bus_error  = st_next.source_bus_error  | evt_set[`DCS_EVT_BES];
        st_next.bed  = st_next.bed  | evt_set[`DCS_EVT_BED];
        st_next.done = st_next.done | evt_set[`DCS_EVT_DONE];
        st_next.req  = (st_next.phase != PH_IDLE)
                     & ~engine_in.selected;
    end

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            st_reg <= `DCS_RESET_STATE;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign pready_out         = access;
    assign pslverr_out        = access & ~mapped;
    assign prdata_out         = st_reg.prdata;
    assign channel_active_out = busy;
    assign pending_out        = st_reg.req;
    assign size_out           = st_reg.size;
    assign abort_out          = st_reg.abort;
    assign irq_out            = st_reg.int_en
                              & |(st_reg.evt_status
                                  & st_reg.evt_enable);

endmodule // dcs_channel

// File: tb/dcs_channel_props.sv
// Port checker of one channel's count, status and interrupt logic.
// Assumes it is bound onto dcs_channel and sees only that module's ports.
module dcs_channel_props (
    input wire logic                  clock_in,
    input wire logic                  reset_in,
    input wire dcs_pkg::dcs_apb_req_s apb_in,
    input wire logic                  pready_out,
    input wire logic                  pslverr_out,
    input wire logic [31:0]           prdata_out,
    input wire dcs_pkg::dcs_engine_s  engine_in,
    input wire logic                  channel_active_out,
    input wire logic                  pending_out,
    input wire logic [1:0]            size_out,
    input wire logic                  abort_out,
    input wire logic                  irq_out
);
    import dcs_pkg::*;
    logic wr_acc;
    logic clr_wr;
    logic start_wr;
    logic end_evt;
    assign wr_acc = apb_in.psel && apb_in.penable && apb_in.pwrite;
    assign clr_wr = wr_acc && apb_in.paddr == 8'h00 && apb_in.pwdata[24];
    assign start_wr = wr_acc && apb_in.paddr == 8'h04 && apb_in.pwdata[8];
    assign end_evt = engine_in.write_done || engine_in.read_error
        || engine_in.write_error || clr_wr;
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    a_pending_late: assert property (
        !clr_wr |=> pending_out
        == (channel_active_out && !$past(engine_in.selected)))
        else $error("pending flag wrong");
    a_abort_pulse: assert property (
        clr_wr && channel_active_out
        |=> abort_out && !channel_active_out ##1 !abort_out)
        else $error("abort pulse wrong");
    a_clear_idle: assert property (
        clr_wr && !channel_active_out |=> !irq_out && !channel_active_out)
        else $error("clear left interrupt");
    a_zero_write: assert property (
        wr_acc && apb_in.paddr == 8'h00 && !apb_in.pwdata[24]
        && !channel_active_out |=> $stable(irq_out) && !channel_active_out)
        else $error("zero write had effect");
    a_irq_cause: assert property (
        $rose(irq_out) |-> $past(channel_active_out || wr_acc))
        else $error("interrupt without cause");
    a_busy_start: assert property (
        $rose(channel_active_out) |-> $past(start_wr))
        else $error("busy without start");
    a_busy_end: assert property (
        $fell(channel_active_out) |-> $past(end_evt))
        else $error("busy ended without cause");
    a_size_hold: assert property (
        $changed(size_out) |-> $past(wr_acc && apb_in.paddr == 8'h04))
        else $error("size changed alone");
endmodule // dcs_channel_props

bind dcs_channel dcs_channel_props i_dcs_channel_props (.clock_in,
    .reset_in, .apb_in, .pready_out, .pslverr_out, .prdata_out,
    .engine_in, .channel_active_out, .pending_out, .size_out,
    .abort_out, .irq_out);

// File: tb/dcs_bus_model.sv
// Behavioural system bus facing one channel: write pulses and errors.
// Assumes the bench steers stalls, error pulses and pointer bits.
module dcs_bus_model (
    input  wire logic            clock_in,
    input  wire logic            reset_in,
    input  wire logic            active_in,
    input  wire logic            stall_in,
    input  wire logic            rd_err_in,
    input  wire logic            wr_err_in,
    input  wire logic [7:0]      ptr_in,
    output dcs_pkg::dcs_engine_s eng_out
);
    import dcs_pkg::*;
    logic phase_reg;
    logic addr_reg;
    logic data_reg;
    // Address and data completions alternate; a stall drops both pulses.
    always_ff @(posedge clock_in) begin
        if (reset_in || !active_in || stall_in) begin
            phase_reg <= 1'b0;
            addr_reg  <= 1'b0;
            data_reg  <= 1'b0;
        end else begin
            phase_reg <= !phase_reg;
            addr_reg  <= !phase_reg;
            data_reg  <= phase_reg;
        end
    end
    always_comb begin
        eng_out                 = '0;
        eng_out.write_addr_done = addr_reg;
        eng_out.write_done      = data_reg;
        eng_out.read_error      = rd_err_in;
        eng_out.write_error     = wr_err_in;
        eng_out.selected        = active_in && !stall_in;
        eng_out.source_pointer  = ptr_in[3:0];
        eng_out.dest_pointer    = ptr_in[7:4];
    end
endmodule // dcs_bus_model

// File: tb/tb_dcs_channel.sv
// Self-checking bench of one channel's count, status and interrupt.
// Assumes the design, its package, the bus model and the checker.
module tb_dcs_channel;
    timeunit 1ns;
    timeprecision 1ns;
    import dcs_pkg::*;
    logic         clock_in = 1'b0;
    logic         reset_in = 1'b1;
    dcs_apb_req_s req = '0;
    dcs_engine_s  eng;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic         active;
    logic         irq;
    logic         stall = 1'b0;
    logic         rerr = 1'b0;
    logic         werr = 1'b0;
    logic [7:0]   ptr = 8'h00;
    logic [31:0]  rdat;
    logic         err_s;
    logic [23:0]  cnt;
    logic [1:0]   sz;
    int           fail_count = 0;
    int           num_checks = 0;
    int           cycles = 0;
    logic [1:0]   cf_sz [6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h1};
    logic [23:0]  cf_cnt [6] = '{24'h00_0003, 24'h00_0006, 24'h00_0018,
        24'h00_0000, 24'h00_0008, 24'h00_0002};
    logic [7:0]   cf_ptr [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h10};
    always #50 clock_in = !clock_in;
    dcs_channel i_dcs_channel (.clock_in(clock_in), .reset_in(reset_in),
        .apb_in(req), .pready_out(pready), .pslverr_out(pslverr),
        .prdata_out(prdata), .engine_in(eng), .channel_active_out(active),
        .pending_out(), .size_out(), .abort_out(), .irq_out(irq));
    dcs_bus_model i_dcs_bus_model (.clock_in(clock_in),
        .reset_in(reset_in), .active_in(active), .stall_in(stall),
        .rd_err_in(rerr), .wr_err_in(werr), .ptr_in(ptr), .eng_out(eng));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] step_of(input logic [1:0] s);
        return (s == 2'h3) ? 24'h00_0010 : 24'h00_0001 << s;
    endfunction
    function automatic logic [31:0] ctl(input logic ie, input logic [1:0] s);
        return {ie, 23'h00_0001, 6'h00, s};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, got);
        num_checks++;
        if (got !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock_in);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock_in);
        req.penable <= 1'b1;
        // Only the bench timeout ends a wait for the answer.
        do begin
            @(posedge clock_in);
        end while (pready !== 1'b1);
        rdat = prdata;
        err_s = pslverr;
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("read %h", a), e, rdat);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge clock_in);
        while (active === 1'b1 && n < 300) begin
            @(negedge clock_in);
            n++;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // The whole run needs well under a thousand cycles.
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hbec0));
        repeat (3) @(posedge clock_in);
        reset_in <= 1'b0;
        rd(8'h00, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        wr(8'h10, 32'h0000_000F);
        for (int s = 0; s < 4; s++) begin
            sz = s[1:0];
            cnt = step_of(sz) * 24'($urandom_range(4, 2));
            wr(8'h00, {8'h00, cnt});
            stall <= 1'b1;
            wr(8'h04, ctl(sz[0], sz));
            rd(8'h00, {8'h06, cnt});
            stall <= 1'b0;
            @(posedge clock_in);
            stall <= 1'b1;
            rd(8'h00, {8'h06, cnt - step_of(sz)});
            stall <= 1'b0;
            wait_idle();
            chk("irq", 32'(sz[0]), 32'(irq));
            rd(8'h00, 32'h0100_0000);
            rd(8'h08, 32'h0000_0001);
            wr(8'h00, {8'h76, cnt});
            rd(8'h00, {8'h01, cnt});
            wr(8'h10, 32'h0000_0000);
            rd(8'h00, {8'h01, cnt});
            chk("irq", 32'h0000_0000, 32'(irq));
            wr(8'h10, 32'h0000_000F);
            wr(8'h0C, 32'h0000_000F);
            rd(8'h08, 32'h0000_0000);
            wr(8'h00, 32'h0100_0000);
            rd(8'h00, 32'h0000_0000);
        end
        for (int i = 0; i < 6; i++) begin
            ptr <= cf_ptr[i];
            wr(8'h00, {8'h00, cf_cnt[i]});
            wr(8'h04, ctl(1'b1, cf_sz[i]));
            wr(8'h00, {8'h00, cf_cnt[i]});
            chk("active", 32'h0000_0000, 32'(active));
            rd(8'h00, {8'h41, cf_cnt[i]});
            rd(8'h08, 32'h0000_0003);
            chk("irq", 32'h0000_0001, 32'(irq));
            wr(8'h00, 32'h0100_0000);
            rd(8'h00, 32'h0000_0000);
        end
        ptr <= 8'h00;
        for (int e = 0; e < 2; e++) begin
            wr(8'h00, 32'h0000_0040);
            stall <= 1'b1;
            wr(8'h04, ctl(1'b1, 2'h2));
            rerr <= (e == 0);
            werr <= (e == 1);
            @(posedge clock_in);
            rerr <= 1'b0;
            werr <= 1'b0;
            wait_idle();
            rd(8'h00, e ? 32'h1100_0040 : 32'h2100_0040);
            rd(8'h08, e ? 32'h0000_0009 : 32'h0000_0005);
            stall <= 1'b0;
            wr(8'h00, 32'h0100_0000);
            rerr <= 1'b1;
            @(posedge clock_in);
            rerr <= 1'b0;
            rd(8'h00, 32'h0000_0000);
        end
        wr(8'h00, 32'h0000_0040);
        stall <= 1'b1;
        wr(8'h04, ctl(1'b1, 2'h2));
        wr(8'h00, 32'h0100_0020);
        @(negedge clock_in);
        chk("active", 32'h0000_0000, 32'(active));
        rd(8'h00, 32'h0000_0020);
        stall <= 1'b0;
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, 32'(err_s));
        chk("unmapped", 32'h0000_0000, rdat);
        wrap_up();
    end
endmodule // tb_dcs_channel
